// ==== src/pcs_params.svh ====
// pcs_params.svh: offsets, field positions, reset values and timing counts
// assumes: included by the socket status top module pcs_socket_top
`ifndef PCS_PARAMS_SVH
`define PCS_PARAMS_SVH

// socket count and per-socket register slots
`define PCS_NSOCK        4
`define PCS_REG_CTRL     2'h0
`define PCS_REG_STAT     2'h1
`define PCS_REG_PWR      2'h2

// control register fields
`define PCS_CTRL_W       5
`define PCS_CTRL_RST_VAL 5'h0
`define PCS_CTRL_IO      0
`define PCS_CTRL_WPEN    1
`define PCS_CTRL_RESET   2
`define PCS_CTRL_POWER   3
`define PCS_CTRL_AUDIO   4

// interface status register fields
`define PCS_STAT_WPW     0
`define PCS_STAT_BATTERY_DETECT_ONE    1
`define PCS_STAT_BATTERY_DETECT_TWO    2
`define PCS_STAT_BATT_LO 3
`define PCS_STAT_WAIT    5
`define PCS_STAT_IO      6

// power configuration register fields
`define PCS_PWR_VS1      0
`define PCS_PWR_VS2      1
`define PCS_PWR_ON       2

// card strobe timing: least width in ns, rounded up to clock cycles
`define PCS_CLK_NS       20
`define PCS_STROBE_NS    300
`define PCS_STROBE_CYC   ((`PCS_STROBE_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS)
`define PCS_CNT_W        4

`endif

// ==== src/pcs_pkg.sv ====
// pcs_pkg: types shared by the socket status and cycle logic
// assumes: pcs_params.svh sits in the include path
package pcs_pkg;

    // card cycle sequencer, gray along idle-setup-strobe-next
    typedef enum logic [1:0] {
        PCS_IDLE   = 2'b00,
        PCS_SETUP  = 2'b01,
        PCS_STROBE = 2'b11,
        PCS_NEXT   = 2'b10
    } pcs_cyc_state_type;

    // decoded battery condition
    typedef enum logic [1:0] {
        PCS_BATT_FAIL = 2'b00,
        PCS_BATT_WARN = 2'b01,
        PCS_BATT_GOOD = 2'b10
    } pcs_batt_type;

endpackage

// ==== src/pcs_sync.sv ====
// pcs_sync: two-flop synchroniser for a bundle of card pin levels
// assumes: each bit is an independent slow level from a card pin
`timescale 1ns/100ps
`default_nettype none

module pcs_sync #(
    parameter int WIDTH = 24
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // raw pins and synchronised copy
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);

    // both stages, first read only by the second
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } pcs_sync_type;

    pcs_sync_type s;       // registered state
    pcs_sync_type next_s;  // next state

    ////////////////////////////////////////////////////////////////////////
    // next state: shift pins through two stages
    always_comb begin
        next_s        = s;
        next_s.meta   = i_d;
        next_s.stable = s.meta;
    end

    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_q = s.stable;

endmodule

`default_nettype wire

// ==== src/pcs_socket_top.sv ====
// pcs_socket_top: status, reset, power sensing and narrow-cycle splitting
// for four card sockets behind one register port and one cycle port
// assumes: pins are asynchronous; host cycle requests come on i_clk
//
// Function
// - wp/wide pin meaning chosen by card type
// - protected memory writes blocked only when enabled
// - wp/wide pin level readable in status
// - wide pin sets number of card cycles
// - narrow 16-bit I/O becomes even/odd bytes
// - card reset output driven from control
// - wait input stretches the card strobe
// - battery good or warning decoded from pins
// - battery detect one low means failed
// - battery detect levels kept in status
// - status change level kept in status
// - I/O card audio forwarded to speaker
// - voltage sense sampled before power applied
// - sampled voltage sense kept in power register
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`include "pcs_params.svh"
`timescale 1ns/100ps
`default_nettype none

module pcs_socket_top
    import pcs_pkg::*;
(
    // clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    // register port
    input  wire logic [3:0]            i_addr,
    input  wire logic [7:0]            i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [7:0]            o_rdata,
    // host cycle request
    input  wire logic                  i_cyc_req,
    input  wire logic [1:0]            i_cyc_sock,
    input  wire logic                  i_cyc_io,
    input  wire logic                  i_cyc_write,
    input  wire logic [1:0]            i_cyc_size,
    input  wire logic                  i_cyc_odd,
    output logic                       o_cyc_ready,
    output logic                       o_cyc_done,
    output logic                       o_cyc_blocked,
    // card cycle control
    output logic      [1:0]            o_card_sock,
    output logic                       o_card_strobe,
    output logic                       o_card_write,
    output logic                       o_card_io,
    output logic      [1:0]            o_card_ce_n,
    // socket pins, one bit per socket
    input  wire logic [`PCS_NSOCK-1:0] i_io_port_wide_n,
    input  wire logic [`PCS_NSOCK-1:0] i_card_wait_n,
    input  wire logic [`PCS_NSOCK-1:0] i_battery_detect_one,
    input  wire logic [`PCS_NSOCK-1:0] i_battery_detect_two,
    input  wire logic [`PCS_NSOCK-1:0] i_voltage_sense_one,
    input  wire logic [`PCS_NSOCK-1:0] i_voltage_sense_two,
    output logic      [`PCS_NSOCK-1:0] o_card_reset,
    output logic      [`PCS_NSOCK-1:0] o_sock_power,
    // host side speaker
    output logic                       o_host_speaker_out_n
);

    localparam int NS = `PCS_NSOCK;

    // whole module state
    typedef struct packed {
        logic [NS-1:0][`PCS_CTRL_W-1:0] ctrl;    // per-socket control
        logic [NS-1:0][1:0]             vs;      // sampled voltage sense
        logic [NS-1:0]                  power;   // supply applied
        pcs_cyc_state_type              state;   // cycle sequencer
        logic [1:0]                     sock;    // socket of this transfer
        logic                           io;      // i/o transfer
        logic                           write;   // write transfer
        logic [2:0]                     remain;  // bytes still to move
        logic [1:0]                     lane;    // current byte lane
        logic                           wide;    // current cycle is 16-bit
        logic [`PCS_CNT_W-1:0]          cnt;     // strobe width count
        logic                           strobe;  // card strobe
        logic [1:0]                     ce_n;    // even/odd byte enables
        logic                           done;    // transfer finished
        logic                           blocked; // write refused
        logic [7:0]                     rdata;   // read data
        logic                           spk_n;   // speaker level
    } pcs_state_type;

    pcs_state_type s;       // registered state
    pcs_state_type next_s;  // next state

    // synchronised pins
    logic [NS-1:0] wpw;     // protect / wide level
    logic [NS-1:0] wait_n;  // cycle wait
    logic [NS-1:0] battery_detect_one;    // battery one / status change
    logic [NS-1:0] battery_detect_two;    // battery two / audio
    logic [NS-1:0] vs1;     // voltage sense one
    logic [NS-1:0] vs2;     // voltage sense two

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser, all socket inputs in one bundle
    pcs_sync #(
        .WIDTH (6 * NS)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_d     ({i_voltage_sense_two, i_voltage_sense_one,
                   i_battery_detect_two, i_battery_detect_one,
                   i_card_wait_n, i_io_port_wide_n}),
        .o_q     ({vs2, vs1, battery_detect_two, battery_detect_one, wait_n, wpw})
    );

    ////////////////////////////////////////////////////////////////////////
    // battery condition from the two detect levels
    function automatic pcs_batt_type batt_decode(input logic b1, input logic b2);
        pcs_batt_type r;
        if (!b1) begin
            r = PCS_BATT_FAIL;
        end else if (b2) begin
            r = PCS_BATT_GOOD;
        end else begin
            r = PCS_BATT_WARN;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state: registers, speaker and cycle sequencer
    always_comb begin
        logic [1:0]   rs;      // addressed socket
        logic [1:0]   rr;      // addressed register slot
        logic         spk_on;  // any socket sounding
        logic [2:0]   step;    // bytes moved by current cycle
        pcs_batt_type batt;    // decoded battery of addressed socket
        rs             = i_addr[3:2];
        rr             = i_addr[1:0];
        spk_on         = 1'b0;
        step           = s.wide ? 3'd2 : 3'd1;
        batt           = batt_decode(battery_detect_one[rs], battery_detect_two[rs]);
        next_s         = s;
        next_s.done    = 1'b0;
        next_s.blocked = 1'b0;
        next_s.rdata   = 8'h00;

        // register writes, control slot only
        if (i_wr && rr == `PCS_REG_CTRL) begin
            next_s.ctrl[rs] = i_wdata[`PCS_CTRL_W-1:0];
            // sense sampled when power is requested
            if (i_wdata[`PCS_CTRL_POWER] && !s.ctrl[rs][`PCS_CTRL_POWER]) begin
                next_s.vs[rs] = {vs2[rs], vs1[rs]};
            end
        end

        // supply follows control one cycle late, after sensing
        for (int k = 0; k < NS; k++) begin
            next_s.power[k] = s.ctrl[k][`PCS_CTRL_POWER];
            if (s.ctrl[k][`PCS_CTRL_IO] && s.ctrl[k][`PCS_CTRL_AUDIO] && !battery_detect_two[k]) begin
                spk_on = 1'b1;
            end
        end
        next_s.spk_n = !spk_on;

        // register reads, data stands one cycle
        if (i_rd) begin
            if (rr == `PCS_REG_CTRL) begin
                next_s.rdata = {3'b000, s.ctrl[rs]};
            end else if (rr == `PCS_REG_STAT) begin
                next_s.rdata[`PCS_STAT_WPW] = wpw[rs];
                next_s.rdata[`PCS_STAT_BATTERY_DETECT_ONE] = battery_detect_one[rs];
                next_s.rdata[`PCS_STAT_BATTERY_DETECT_TWO] = battery_detect_two[rs];
                next_s.rdata[`PCS_STAT_BATT_LO +: 2] = batt;
                next_s.rdata[`PCS_STAT_WAIT] = !wait_n[rs];
                next_s.rdata[`PCS_STAT_IO] = s.ctrl[rs][`PCS_CTRL_IO];
            end else if (rr == `PCS_REG_PWR) begin
                next_s.rdata[`PCS_PWR_VS1] = s.vs[rs][0];
                next_s.rdata[`PCS_PWR_VS2] = s.vs[rs][1];
                next_s.rdata[`PCS_PWR_ON] = s.power[rs];
            end else begin
                next_s.rdata = 8'h00;
            end
        end

        // card cycle sequencer
        case (s.state)
            PCS_IDLE: begin
                if (i_cyc_req) begin
                    next_s.sock  = i_cyc_sock;
                    next_s.io    = i_cyc_io;
                    next_s.write = i_cyc_write;
                    next_s.lane  = {1'b0, i_cyc_odd};
                    // transfer size in bytes
                    case (i_cyc_size)
                        2'd0:    next_s.remain = 3'd1;
                        2'd1:    next_s.remain = 3'd2;
                        default: next_s.remain = 3'd4;
                    endcase
                    // memory card reads pin as protect
                    if (!i_cyc_io && i_cyc_write && wpw[i_cyc_sock]
                        && !s.ctrl[i_cyc_sock][`PCS_CTRL_IO]
                        && s.ctrl[i_cyc_sock][`PCS_CTRL_WPEN]) begin
                        next_s.blocked = 1'b1;
                        next_s.done    = 1'b1;
                    end else begin
                        next_s.state = PCS_SETUP;
                    end
                end
            end
            PCS_SETUP: begin
                next_s.wide = (!s.io || !wpw[s.sock]) && s.remain >= 3'd2 && !s.lane[0];
                if (next_s.wide) begin
                    next_s.ce_n = 2'b00;
                end else if (s.lane[0]) begin
                    next_s.ce_n = 2'b01;
                end else begin
                    next_s.ce_n = 2'b10;
                end
                next_s.strobe = 1'b1;
                next_s.cnt    = `PCS_CNT_W'(`PCS_STROBE_CYC - 1);
                next_s.state  = PCS_STROBE;
            end
            PCS_STROBE: begin
                if (s.cnt != '0) begin
                    next_s.cnt = s.cnt - 1'b1;
                end else if (wait_n[s.sock]) begin
                    next_s.strobe = 1'b0;
                    next_s.ce_n   = 2'b11;
                    next_s.state  = PCS_NEXT;
                end
            end
            PCS_NEXT: begin
                next_s.remain = s.remain - step;
                next_s.lane   = s.lane + step[1:0];
                if (s.remain == step) begin
                    next_s.done  = 1'b1;
                    next_s.state = PCS_IDLE;
                end else begin
                    next_s.state = PCS_SETUP;
                end
            end
            default: begin
                next_s.state = PCS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s       <= '0;
            s.ctrl  <= {NS{`PCS_CTRL_RST_VAL}};
            s.state <= PCS_IDLE;
            s.ce_n  <= 2'b11;
            s.spk_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_rdata              = s.rdata;
    assign o_cyc_ready          = (s.state == PCS_IDLE);
    assign o_cyc_done           = s.done;
    assign o_cyc_blocked        = s.blocked;
    assign o_card_sock          = s.sock;
    assign o_card_strobe        = s.strobe;
    assign o_card_write         = s.write;
    assign o_card_io            = s.io;
    assign o_card_ce_n          = s.ce_n;
    assign o_sock_power         = s.power;
    assign o_host_speaker_out_n = s.spk_n;

    always_comb begin
        for (int k = 0; k < NS; k++) begin
            o_card_reset[k] = s.ctrl[k][`PCS_CTRL_RESET];
        end
    end

endmodule

`default_nettype wire

// ==== tb/pcs_socket_properties.sv ====
// pcs_socket_props: port checks on the socket status and cycle top
// assumes: one clock domain, bound to every pcs_socket_top
`timescale 1ns/100ps
`default_nettype none

module pcs_socket_props (
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    // watched ports
    input wire logic       i_rd,
    input wire logic       i_wr,
    input wire logic       i_cyc_req,
    input wire logic       i_cyc_io,
    input wire logic       i_cyc_write,
    input wire logic [3:0] i_card_wait_n,
    input wire logic [7:0] o_rdata,
    input wire logic       o_cyc_ready,
    input wire logic       o_cyc_done,
    input wire logic       o_cyc_blocked,
    input wire logic       o_card_strobe,
    input wire logic [1:0] o_card_sock,
    input wire logic [1:0] o_card_ce_n,
    input wire logic [3:0] o_card_reset,
    input wire logic [3:0] o_sock_power
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // request accepted by an idle sequencer
    sequence req_taken;
        i_cyc_req && o_cyc_ready;
    endsequence
    // least strobe width, fifteen cycles
    sequence strobe_min;
        o_card_strobe[*8] ##1 o_card_strobe[*7];
    endsequence

    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    // protected write refusal
    blocked_cause_a: assert property (
        o_cyc_blocked |-> o_cyc_done && $past(i_cyc_req && o_cyc_ready && i_cyc_write && !i_cyc_io))
        else $error("blocked without memory write request");
    done_bound_a: assert property (req_taken |-> ##[1:300] o_cyc_done)
        else $error("transfer never completed");
    done_pulse_a: assert property (o_cyc_done |=> !o_cyc_done) else $error("done longer than one cycle");
    // wait stretch
    wait_hold_a: assert property (
        o_card_strobe && !i_card_wait_n[o_card_sock] && $past(!i_card_wait_n[o_card_sock])
        && $past(!i_card_wait_n[o_card_sock], 2) |=> o_card_strobe) else $error("strobe ended during wait");
    strobe_min_a: assert property ($rose(o_card_strobe) |-> strobe_min) else $error("strobe too short");
    ce_idle_a: assert property (!o_card_strobe |-> o_card_ce_n == 2'b11) else $error("chip enable outside strobe");
    busy_a: assert property (o_card_strobe |-> !o_cyc_ready) else $error("ready during card cycle");
    // reset follows control write
    reset_cause_a: assert property ($changed(o_card_reset) |-> $past(i_wr) || $past(i_wr, 2))
        else $error("card reset moved without write");
    power_late_a: assert property ($changed(o_sock_power) |-> $past(i_wr, 2)) else $error("power moved untimely");
endmodule

bind pcs_socket_top pcs_socket_props pcs_socket_props_inst (.i_clk, .i_rst_n, .i_rd, .i_wr, .i_cyc_req,
    .i_cyc_io, .i_cyc_write, .i_card_wait_n, .o_rdata, .o_cyc_ready, .o_cyc_done, .o_cyc_blocked,
    .o_card_strobe, .o_card_sock, .o_card_ce_n, .o_card_reset, .o_sock_power);

`default_nettype wire

// ==== tb/pcs_card_model.sv ====
// pcs_card_model: inserted cards, shared protect/wide pin and wait
// assumes: bench sets card type, port width, switch and slowness
`timescale 1ns/100ps
`default_nettype none

module pcs_card_model (
    // clock and card cycle
    input  wire logic       i_clk,
    input  wire logic       i_card_strobe,
    input  wire logic [1:0] i_card_sock,
    // card setup per socket
    input  wire logic [3:0] i_io_card,
    input  wire logic [3:0] i_port16,
    input  wire logic [3:0] i_protect,
    input  wire logic [3:0] i_slow,
    // one card's signal-on-change bit and its four change bits
    input  wire logic       i_signal_on_change,
    input  wire logic [3:0] i_change_bits,
    output logic            o_card_status_changed_n,
    // card pins
    output logic      [3:0] o_io_port_wide_n,
    output logic      [3:0] o_card_wait_n
);
    int   stall    = 0;    // wait cycles left
    logic strobe_q = 1'b0; // edge finder

    always_comb o_io_port_wide_n = (i_io_card & ~i_port16) | (~i_io_card & i_protect);

    // changed is the OR of change bits, line low only with both set
    always_comb o_card_status_changed_n = !(i_signal_on_change && (|i_change_bits));

    // slow card holds wait twenty cycles per strobe
    always @(posedge i_clk) begin
        strobe_q <= i_card_strobe;
        if (i_card_strobe && !strobe_q && i_slow[i_card_sock]) begin
            stall <= 20;
        end else if (stall > 0) begin
            stall <= stall - 1;
        end
    end
    always_comb o_card_wait_n = (stall > 0) ? ~(4'h1 << i_card_sock) : 4'hf;
endmodule

`default_nettype wire

// ==== tb/pc_card_socket_status_sizing_test.sv ====
// pc_card_socket_status_sizing_test: registers, pins and card cycles
// assumes: card model on the socket pins, bench drives the rest
`timescale 1ns/100ps
`default_nettype none

module pc_card_socket_status_sizing_test;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, str_d = 1'b0, long_f = 1'b0;
    logic [3:0] addr = 4'h0, battery_detect_one = 4'hf, battery_detect_two = 4'hf, vs1 = 4'h0, vs2 = 4'h0, card_reset, sock_power;
    logic [3:0] io_card = 4'h4, port16 = 4'h0, protect = 4'h2, slow = 4'h1, wide_n, wait_n;
    logic [7:0] wdata = 8'h00, rdata;
    logic cyc_req = 1'b0, cyc_io = 1'b0, cyc_write = 1'b0, cyc_odd = 1'b0, ready, done, blocked, strobe, spk_n;
    logic [1:0] cyc_sock = 2'b00, cyc_size = 2'b00, card_sock, ce_n, ce_a = 2'b11, ce_b = 2'b11;
    logic [2:0] nstr = 3'd0;
    logic cw, cio, soc = 1'b0, card_status_changed_n_n;
    logic [3:0] chg = 4'h0;
    logic [15:0] q[$];
    int errors = 0, tests_run = 0, len = 0, seed = 32'hccfb_65d5;

    pcs_socket_top pcs_socket_top_inst (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cyc_req(cyc_req), .i_cyc_sock(cyc_sock), .i_cyc_io(cyc_io),
        .i_cyc_write(cyc_write), .i_cyc_size(cyc_size), .i_cyc_odd(cyc_odd), .o_cyc_ready(ready),
        .o_cyc_done(done), .o_cyc_blocked(blocked), .o_card_sock(card_sock), .o_card_strobe(strobe),
        .o_card_write(cw), .o_card_io(cio), .o_card_ce_n(ce_n), .i_io_port_wide_n(wide_n), .i_card_wait_n(wait_n),
        .i_battery_detect_one(battery_detect_one), .i_battery_detect_two(battery_detect_two), .i_voltage_sense_one(vs1),
        .i_voltage_sense_two(vs2), .o_card_reset(card_reset), .o_sock_power(sock_power),
        .o_host_speaker_out_n(spk_n));
    pcs_card_model pcs_card_model_inst (.i_clk(clk), .i_card_strobe(strobe), .i_card_sock(card_sock),
        .i_io_card(io_card), .i_port16(port16), .i_protect(protect), .i_slow(slow),
        .i_signal_on_change(soc), .i_change_bits(chg), .o_card_status_changed_n(card_status_changed_n_n),
        .o_io_port_wide_n(wide_n), .o_card_wait_n(wait_n));

    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    // compare, verdict, result packing
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // blocked, long strobe, strobe count, first and last chip enable
    function automatic logic [15:0] res(input logic b, l, input logic [2:0] n, input logic [1:0] a, c);
        return {7'h00, b, l, n, a, c};
    endfunction

    ////////////////////////////////////////////////////////////////
    // register bus and cycle port
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk); wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] e);
        q.push_back({8'h00, e});
        addr <= a; rd <= 1'b1;
        @(posedge clk); rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cyc(input logic [1:0] s, input logic io, w, input logic [1:0] sz, input logic [15:0] e);
        int n;
        n = 0;
        q.push_back(e);
        cyc_sock <= s; cyc_io <= io; cyc_write <= w; cyc_size <= sz; cyc_req <= 1'b1;
        @(posedge clk); cyc_req <= 1'b0;
        // look at done off the edge that launches it
        do begin
            @(negedge clk); n++;
        end while (done !== 1'b1 && n < 400);
        if (n >= 400) errors++;
        @(posedge clk);
    endtask

    // watcher: takes the oldest note whenever a result shows
    always @(negedge clk) begin
        if (rd_d) check({8'h00, rdata}, q.pop_front());
        rd_d = rd;
        if (strobe && !str_d) begin
            nstr++; len = 0; ce_b = ce_n;
            if (nstr == 3'd1) ce_a = ce_n;
        end
        if (strobe) len++;
        if (len >= 20) long_f = 1'b1;
        str_d = strobe;
        if (done === 1'b1) begin
            check(res(blocked, long_f, nstr, ce_a, ce_b), q.pop_front());
            nstr = 3'd0; long_f = 1'b0; ce_a = 2'b11; ce_b = 2'b11; len = 0;
        end
    end

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [1:0] v, k;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rreg(4'h0, 8'h00);
        rreg(4'h3, 8'h00);
        wreg(4'h4, 8'h02);
        rreg(4'h5, 8'h17);
        cyc(2'd1, 1'b0, 1'b1, 2'd1, res(1'b0 + 1'b1, 1'b0, 3'd0, 2'b11, 2'b11));
        wreg(4'h4, 8'h00);
        cyc(2'd1, 1'b0, 1'b1, 2'd1, res(1'b0, 1'b0, 3'd1, 2'b00, 2'b00));
        cyc(2'd0, 1'b0, 1'b0, 2'd0, res(1'b0, 1'b1, 3'd1, 2'b10, 2'b10));
        // narrow then wide I/O on socket two
        wreg(4'h8, 8'h01);
        cyc(2'd2, 1'b1, 1'b0, 2'd1, res(1'b0, 1'b0, 3'd2, 2'b10, 2'b01));
        cyc(2'd2, 1'b1, 1'b1, 2'd2, res(1'b0, 1'b0, 3'd4, 2'b10, 2'b01));
        check({14'h0000, cw, cio}, 16'h0003);
        port16 <= 4'h4;
        repeat (3) @(posedge clk);
        rreg(4'h9, 8'h56);
        cyc(2'd2, 1'b1, 1'b1, 2'd1, res(1'b0, 1'b0, 3'd1, 2'b00, 2'b00));
        cyc(2'd2, 1'b1, 1'b0, 2'd2, res(1'b0, 1'b0, 3'd2, 2'b00, 2'b00));
        wreg(4'h8, 8'h05);
        check({12'h000, card_reset}, 16'h0004);
        wreg(4'h8, 8'h01);
        for (int i = 0; i < 4; i++) begin
            k = i[1:0];
            battery_detect_one[3] <= k[0]; battery_detect_two[3] <= k[1];
            repeat (3) @(posedge clk);
            rreg(4'hd, {3'b000, !k[0] ? 2'b00 : (k[1] ? 2'b10 : 2'b01), k[1], k[0], 1'b0});
        end
        v = 2'($random(seed));
        {vs2, vs1} <= (8'($random(seed)) & 8'hee) | {3'b000, v[1], 3'b000, v[0]};
        repeat (3) @(posedge clk);
        wreg(4'h0, 8'h08);
        vs1[0] <= ~v[0]; vs2[0] <= ~v[1];
        repeat (3) @(posedge clk);
        rreg(4'h2, {5'b00000, 1'b1, v});
        check({15'h0000, sock_power[0]}, 16'h0001);
        wreg(4'hc, 8'h11);
        rreg(4'hc, 8'h11);
        battery_detect_two[3] <= 1'b0;
        repeat (4) @(posedge clk);
        check({15'h0000, spk_n}, 16'h0000);
        battery_detect_two[3] <= 1'b1;
        repeat (4) @(posedge clk);
        check({15'h0000, spk_n}, 16'h0001);
        // card flags a change, its status line feeds socket three
        soc <= 1'b1; chg <= 4'h4;
        @(posedge clk);
        battery_detect_one[3] <= card_status_changed_n_n;
        repeat (3) @(posedge clk);
        rreg(4'hd, 8'h44);
        final_report();
    end
endmodule

`default_nettype wire
